/* File: verilog/sir_pkg.sv */
// Operation
// - k1/k2 unstable declare or clear raises interrupt when its enable is set
// - new k1/k2 accepted after 3 or 5 identical frames; acceptance interrupts
// - enable bit 7: signal-failure declare or clear interrupts
// - enable bit 6: signal-degrade declare or clear interrupts
// - enable bit 5: each ms-rei detection interrupts
// - enable bit 4: each b2 parity error interrupts
// - enable bit 3: each b1 parity error interrupts
// - enable bit 2: loss-of-frame declare or clear interrupts
// - enable bit 1: severely-errored-frame declare or clear interrupts
// - enable bit 0: loss-of-signal declare or clear interrupts
// - b1 tally is 32 bits over four bytes, byte3 high, byte2 next
// - reading a tally byte returns it then zeroes it; bytes reset zero
// - per-bit mode adds count of wrong bits in each b1 byte
// - per-frame mode adds one per frame with any b1 error
// - register set replicated three times, channel selected by 0x05 to 0x07
// - status bit shows event since last read and clears on read
package sir_pkg;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam logic [7:0] CHAN_FIRST = 8'h05;
    localparam logic [7:0] CHAN_LAST = 8'h07;
    localparam logic [11:0] OFS_CONTROL = 12'h100;
    localparam logic [11:0] OFS_K1_ACCEPTED = 12'h101;
    localparam logic [11:0] OFS_K2_ACCEPTED = 12'h102;
    localparam logic [11:0] OFS_DEFECT_STATE = 12'h107;
    localparam logic [11:0] OFS_IRQ_STATUS1 = 12'h10B;
    localparam logic [11:0] OFS_IRQ_STATUS0 = 12'h10C;
    localparam logic [11:0] OFS_IRQ_ENABLE1 = 12'h10E;
    localparam logic [11:0] OFS_IRQ_ENABLE0 = 12'h10F;
    localparam logic [11:0] OFS_TALLY3 = 12'h110;
    localparam logic [11:0] OFS_TALLY2 = 12'h111;
    localparam logic [11:0] OFS_TALLY1 = 12'h112;
    localparam logic [11:0] OFS_TALLY0 = 12'h113;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int EN0_SF = 7;
    localparam int EN0_SD = 6;
    localparam int EN0_REI = 5;
    localparam int EN0_B2 = 4;
    localparam int EN0_B1 = 3;
    localparam int EN0_LOF = 2;
    localparam int EN0_SEF = 1;
    localparam int EN0_LOS = 0;
    localparam int EN1_KUNSTABLE = 1;
    localparam int EN1_KNEW = 0;
    localparam int EN1_UNUSED = 2;
    localparam int CTL_PER_FRAME = 0;
    localparam int CTL_K_FIVE = 1;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] TALLY_RST = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // k1/k2 persistence counts
    // ------------------------------------------------------------
    localparam logic [2:0] K_PERSIST_SHORT = 3'h3;
    localparam logic [2:0] K_PERSIST_LONG = 3'h5;

    // ------------------------------------------------------------
    // per-channel signals from the section overhead receiver
    // ------------------------------------------------------------
    typedef struct packed {
        logic sf;
        logic sd;
        logic lof;
        logic sef;
        logic los;
        logic k_unstable;
        logic ms_rei;
        logic b2_err;
        logic b1_valid;
        logic [7:0] b1_mask;
        logic k_valid;
        logic [15:0] k_value;
    } sir_rx_t;

    // ------------------------------------------------------------
    // microprocessor port request
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } sir_cpu_t;

endpackage

/* File: verilog/sir_b1_tally.sv */
module sir_b1_tally
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic per_frame,
    input wire logic [3:0] byte_clr,
    // receiver
    input wire logic b1_valid,
    input wire logic [7:0] b1_mask,
    // tally
    output logic [31:0] tally
);

    logic [31:0] tally_reg;
    logic [31:0] tally_next;
    logic [3:0] bits_wrong;
    logic [31:0] incr;
    logic [31:0] kept;

    always_comb
    begin
        bits_wrong = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            bits_wrong = bits_wrong + {3'h0, b1_mask[i]};
        end
        incr = 32'h0;
        if (b1_valid)
        begin
            if (per_frame)
            begin
                incr = {31'h0, |b1_mask};
            end
            else
            begin
                incr = {28'h0, bits_wrong};
            end
        end
        // the read byte is zeroed first so a same-cycle error is still counted
        kept = tally_reg;
        for (int b = 0; b < 4; b++)
        begin
            if (byte_clr[b])
            begin
                kept[b*8 +: 8] = sir_pkg::TALLY_RST;
            end
        end
        tally_next = kept + incr;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tally_reg <= {4{sir_pkg::TALLY_RST}};
        end
        else
        begin
            tally_reg <= tally_next;
        end
    end

    assign tally = tally_reg;

endmodule

/* File: verilog/sir_section_irq.sv */
module sir_section_irq
#(
    parameter int CHANNELS = 3
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // microprocessor port
    input wire sir_pkg::sir_cpu_t cpu_req,
    output logic [7:0] cpu_rdata,
    // receiver events, one entry per channel
    input wire sir_pkg::sir_rx_t [CHANNELS-1:0] rx_in,
    // interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] enable0_reg [CHANNELS];
    logic [7:0] enable0_next [CHANNELS];
    logic [7:0] enable1_reg [CHANNELS];
    logic [7:0] enable1_next [CHANNELS];
    logic [7:0] control_reg [CHANNELS];
    logic [7:0] control_next [CHANNELS];
    logic [7:0] status0_reg [CHANNELS];
    logic [7:0] status0_next [CHANNELS];
    logic [1:0] status1_reg [CHANNELS];
    logic [1:0] status1_next [CHANNELS];
    logic [5:0] defect_reg [CHANNELS];
    logic [5:0] defect_next [CHANNELS];
    logic [15:0] k_cand_reg [CHANNELS];
    logic [15:0] k_cand_next [CHANNELS];
    logic [2:0] k_cnt_reg [CHANNELS];
    logic [2:0] k_cnt_next [CHANNELS];
    logic [15:0] k_acc_reg [CHANNELS];
    logic [15:0] k_acc_next [CHANNELS];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic irq_reg;
    logic irq_next;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [7:0] chan_field;
    logic [11:0] ofs;
    logic chan_hit;
    logic [7:0] chan_idx;
    logic [31:0] tally [CHANNELS];
    logic [3:0] tally_clr [CHANNELS];
    logic [CHANNELS-1:0] rd_hit;
    logic [CHANNELS-1:0] wr_hit;
    logic [CHANNELS-1:0] k_new;
    logic [5:0] defect_chg [CHANNELS];

    assign chan_field = cpu_req.addr[sir_pkg::ADDR_W-1 -: 8];
    assign ofs = cpu_req.addr[11:0];
    assign chan_hit = (chan_field >= sir_pkg::CHAN_FIRST) && (chan_field <= sir_pkg::CHAN_LAST);
    assign chan_idx = chan_field - sir_pkg::CHAN_FIRST;

    // ------------------------------------------------------------
    // b1 tallies
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : gen_tally
            always_comb
            begin
                tally_clr[g] = 4'h0;
                if (cpu_req.rd && chan_hit && (chan_idx == 8'(g)))
                begin
                    tally_clr[g][3] = (ofs == sir_pkg::OFS_TALLY3);
                    tally_clr[g][2] = (ofs == sir_pkg::OFS_TALLY2);
                    tally_clr[g][1] = (ofs == sir_pkg::OFS_TALLY1);
                    tally_clr[g][0] = (ofs == sir_pkg::OFS_TALLY0);
                end
            end

            sir_b1_tally u_tally
            (
                .clk(clk),
                .sys_rst(sys_rst),
                .per_frame(control_reg[g][sir_pkg::CTL_PER_FRAME]),
                .byte_clr(tally_clr[g]),
                .b1_valid(rx_in[g].b1_valid),
                .b1_mask(rx_in[g].b1_mask),
                .tally(tally[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // per-channel bus strobes
    // ------------------------------------------------------------
    always_comb
    begin
        for (int c = 0; c < CHANNELS; c++)
        begin
            rd_hit[c] = cpu_req.rd && chan_hit && (chan_idx == 8'(c));
            wr_hit[c] = cpu_req.wr && chan_hit && (chan_idx == 8'(c));
        end
    end

    // ------------------------------------------------------------
    // enables and control
    // ------------------------------------------------------------
    always_comb
    begin
        for (int c = 0; c < CHANNELS; c++)
        begin
            enable0_next[c] = enable0_reg[c];
            enable1_next[c] = enable1_reg[c];
            control_next[c] = control_reg[c];
            if (wr_hit[c])
            begin
                case (ofs)
                    sir_pkg::OFS_IRQ_ENABLE0:
                    begin
                        enable0_next[c] = cpu_req.wdata;
                    end
                    sir_pkg::OFS_IRQ_ENABLE1:
                    begin
                        enable1_next[c] = cpu_req.wdata & ~(8'h01 << sir_pkg::EN1_UNUSED);
                    end
                    sir_pkg::OFS_CONTROL:
                    begin
                        control_next[c] = cpu_req.wdata & 8'h03;
                    end
                    default:
                    begin
                        control_next[c] = control_reg[c];
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        for (int c = 0; c < CHANNELS; c++)
        begin
            if (sys_rst)
            begin
                enable0_reg[c] <= sir_pkg::ENABLE_RST;
                enable1_reg[c] <= sir_pkg::ENABLE_RST;
                control_reg[c] <= sir_pkg::CONTROL_RST;
            end
            else
            begin
                enable0_reg[c] <= enable0_next[c];
                enable1_reg[c] <= enable1_next[c];
                control_reg[c] <= control_next[c];
            end
        end
    end

    // ------------------------------------------------------------
    // defect history
    // ------------------------------------------------------------
    // any edge of a defect level is a change event
    always_comb
    begin
        for (int c = 0; c < CHANNELS; c++)
        begin
            defect_next[c] = {rx_in[c].sf, rx_in[c].sd, rx_in[c].lof, rx_in[c].sef, rx_in[c].los, rx_in[c].k_unstable};
            defect_chg[c] = defect_next[c] ^ defect_reg[c];
        end
    end

    always_ff @(posedge clk)
    begin
        for (int c = 0; c < CHANNELS; c++)
        begin
            if (sys_rst)
            begin
                defect_reg[c] <= 6'h0;
            end
            else
            begin
                defect_reg[c] <= defect_next[c];
            end
        end
    end

    // ------------------------------------------------------------
    // k1/k2 persistence filter
    // ------------------------------------------------------------
    always_comb
    begin
        logic [2:0] target;
        target = sir_pkg::K_PERSIST_SHORT;
        for (int c = 0; c < CHANNELS; c++)
        begin
            k_cand_next[c] = k_cand_reg[c];
            k_cnt_next[c] = k_cnt_reg[c];
            k_acc_next[c] = k_acc_reg[c];
            k_new[c] = 1'b0;
            target = control_reg[c][sir_pkg::CTL_K_FIVE] ? sir_pkg::K_PERSIST_LONG : sir_pkg::K_PERSIST_SHORT;
            if (rx_in[c].k_valid)
            begin
                if (rx_in[c].k_value == k_cand_reg[c])
                begin
                    if (k_cnt_reg[c] < target)
                    begin
                        k_cnt_next[c] = k_cnt_reg[c] + 3'h1;
                    end
                end
                else
                begin
                    k_cand_next[c] = rx_in[c].k_value;
                    k_cnt_next[c] = 3'h1;
                end
                if ((k_cnt_next[c] >= target) && (k_cand_next[c] != k_acc_reg[c]))
                begin
                    k_acc_next[c] = k_cand_next[c];
                    k_new[c] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        for (int c = 0; c < CHANNELS; c++)
        begin
            if (sys_rst)
            begin
                k_cand_reg[c] <= 16'h0000;
                k_cnt_reg[c] <= 3'h0;
                k_acc_reg[c] <= 16'h0000;
            end
            else
            begin
                k_cand_reg[c] <= k_cand_next[c];
                k_cnt_reg[c] <= k_cnt_next[c];
                k_acc_reg[c] <= k_acc_next[c];
            end
        end
    end

    // ------------------------------------------------------------
    // events and status
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0] evt0;
        logic [1:0] evt1;
        evt0 = 8'h00;
        evt1 = 2'h0;
        for (int c = 0; c < CHANNELS; c++)
        begin
            evt1[sir_pkg::EN1_KNEW] = k_new[c];
            evt1[sir_pkg::EN1_KUNSTABLE] = defect_chg[c][0];
            evt0[sir_pkg::EN0_SF] = defect_chg[c][5];
            evt0[sir_pkg::EN0_SD] = defect_chg[c][4];
            evt0[sir_pkg::EN0_REI] = rx_in[c].ms_rei;
            evt0[sir_pkg::EN0_B2] = rx_in[c].b2_err;
            evt0[sir_pkg::EN0_B1] = rx_in[c].b1_valid && (|rx_in[c].b1_mask);
            evt0[sir_pkg::EN0_LOF] = defect_chg[c][3];
            evt0[sir_pkg::EN0_SEF] = defect_chg[c][2];
            evt0[sir_pkg::EN0_LOS] = defect_chg[c][1];
            // a set in the same cycle as the clearing read survives
            status0_next[c] = status0_reg[c];
            status1_next[c] = status1_reg[c];
            if (rd_hit[c] && (ofs == sir_pkg::OFS_IRQ_STATUS0))
            begin
                status0_next[c] = 8'h00;
            end
            if (rd_hit[c] && (ofs == sir_pkg::OFS_IRQ_STATUS1))
            begin
                status1_next[c] = 2'h0;
            end
            status0_next[c] = status0_next[c] | evt0;
            status1_next[c] = status1_next[c] | evt1;
        end
    end

    always_ff @(posedge clk)
    begin
        for (int c = 0; c < CHANNELS; c++)
        begin
            if (sys_rst)
            begin
                status0_reg[c] <= 8'h00;
                status1_reg[c] <= 2'h0;
            end
            else
            begin
                status0_reg[c] <= status0_next[c];
                status1_reg[c] <= status1_next[c];
            end
        end
    end

    // ------------------------------------------------------------
    // read data and interrupt
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0] pend;
        pend = 8'h00;
        irq_next = 1'b0;
        rdata_next = rdata_reg;
        if (cpu_req.rd && !chan_hit)
        begin
            rdata_next = sir_pkg::READ_UNMAPPED;
        end
        for (int c = 0; c < CHANNELS; c++)
        begin
            if (rd_hit[c])
            begin
                case (ofs)
                    sir_pkg::OFS_CONTROL: rdata_next = control_reg[c];
                    sir_pkg::OFS_K1_ACCEPTED: rdata_next = k_acc_reg[c][15:8];
                    sir_pkg::OFS_K2_ACCEPTED: rdata_next = k_acc_reg[c][7:0];
                    sir_pkg::OFS_DEFECT_STATE: rdata_next = {2'h0, defect_reg[c]};
                    sir_pkg::OFS_IRQ_STATUS0: rdata_next = status0_reg[c];
                    sir_pkg::OFS_IRQ_STATUS1: rdata_next = {6'h0, status1_reg[c]};
                    sir_pkg::OFS_IRQ_ENABLE0: rdata_next = enable0_reg[c];
                    sir_pkg::OFS_IRQ_ENABLE1: rdata_next = enable1_reg[c];
                    sir_pkg::OFS_TALLY3: rdata_next = tally[c][31:24];
                    sir_pkg::OFS_TALLY2: rdata_next = tally[c][23:16];
                    sir_pkg::OFS_TALLY1: rdata_next = tally[c][15:8];
                    sir_pkg::OFS_TALLY0: rdata_next = tally[c][7:0];
                    default: rdata_next = sir_pkg::READ_UNMAPPED;
                endcase
            end
            // enables gate only the output, status records every event
            pend = (status0_next[c] & enable0_next[c]) | {6'h0, status1_next[c] & enable1_next[c][1:0]};
            irq_next = irq_next | (|pend);
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rdata_reg <= sir_pkg::READ_UNMAPPED;
            irq_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
        end
    end

    assign cpu_rdata = rdata_reg;
    assign irq = irq_reg;

endmodule

/* File: verification/sir_section_irq_asserts.sv */
module sir_section_irq_asserts
#(
    parameter int CHANNELS = 3
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // microprocessor port
    input wire sir_pkg::sir_cpu_t cpu_req,
    input wire logic [7:0] cpu_rdata,
    // receiver and interrupt
    input wire sir_pkg::sir_rx_t [CHANNELS-1:0] rx_in,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // event history
    // ----------
    // history clears in reset like the block's, so a level held over reset counts
    logic [5:0] lv_reg [CHANNELS];
    logic [5:0] lv_next [CHANNELS];
    logic evt;
    logic b1_any;
    logic chan_ok;
    logic [11:0] ofs;
    assign ofs = cpu_req.addr[11:0];
    assign chan_ok = cpu_req.addr[19:12] >= sir_pkg::CHAN_FIRST && cpu_req.addr[19:12] <= sir_pkg::CHAN_LAST;
    always_comb
    begin
        evt = 1'b0;
        b1_any = 1'b0;
        for (int c = 0; c < CHANNELS; c++)
        begin
            lv_next[c] = sys_rst ? 6'h00 : rx_in[c][33:28];
            evt = evt | rx_in[c].ms_rei | rx_in[c].b2_err | rx_in[c].k_valid | (rx_in[c][33:28] != lv_reg[c]);
            evt = evt | (rx_in[c].b1_valid & |rx_in[c].b1_mask);
            b1_any = b1_any | rx_in[c].b1_valid;
        end
    end
    always_ff @(posedge clk)
        lv_reg <= lv_next;
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    AST_RST_QUIET: assert property (disable iff (1'b0) sys_rst |=> !irq && cpu_rdata == 8'h00)
        else $error("outputs not cleared by reset");
    AST_RDATA_HOLDS: assert property (!cpu_req.rd |=> $stable(cpu_rdata))
        else $error("read data moved without a read");
    AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(evt) || $past(evt, 2) || $past(cpu_req.wr) || $past(cpu_req.wr, 2))
        else $error("interrupt rose without event or enable write");
    AST_IRQ_DROP: assert property (!$past(sys_rst) && $fell(irq) |->
        $past(cpu_req.rd) || $past(cpu_req.rd, 2) || $past(cpu_req.wr) || $past(cpu_req.wr, 2))
        else $error("interrupt fell without read or write");
    AST_BAD_CHANNEL: assert property (cpu_req.rd && !chan_ok |=> cpu_rdata == sir_pkg::READ_UNMAPPED)
        else $error("unmapped channel read not zero");
    AST_EN1_SPARE: assert property (cpu_req.rd && chan_ok && ofs == sir_pkg::OFS_IRQ_ENABLE1 |=> !cpu_rdata[2])
        else $error("unused enable bit reads one");
    AST_EN0_BACK: assert property (cpu_req.wr && chan_ok && ofs == sir_pkg::OFS_IRQ_ENABLE0 ##1 !cpu_req.wr ##1
        cpu_req.rd && cpu_req.addr == $past(cpu_req.addr, 2) |=> cpu_rdata == $past(cpu_req.wdata, 3))
        else $error("enable byte readback differs");
    AST_TALLY_CLR: assert property (cpu_req.rd && chan_ok && ofs >= sir_pkg::OFS_TALLY3 && ofs <= sir_pkg::OFS_TALLY0
        && !b1_any ##1 !b1_any ##1 cpu_req.rd && !b1_any && cpu_req.addr == $past(cpu_req.addr, 2)
        |=> cpu_rdata == 8'h00)
        else $error("tally byte not cleared by read");
endmodule

bind sir_section_irq sir_section_irq_asserts #(.CHANNELS(CHANNELS)) u_asserts (.clk(clk), .sys_rst(sys_rst),
    .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .rx_in(rx_in), .irq(irq));

/* File: verification/sir_rx_model.sv */
module sir_rx_model
(
    // clock
    input wire logic clk,
    // section overhead toward the block
    output sir_pkg::sir_rx_t [2:0] rx
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rx = '0;
    // defect levels stay where they are put; any change is an event
    task automatic lv(input int c, input logic [5:0] m);
        @(negedge clk);
        rx[c][33:28] = rx[c][33:28] ^ m;
    endtask
    // f = {rei, b2, b1 frame, k frame}; n frames back to back
    task automatic ev(input int c, input logic [3:0] f, input logic [7:0] m, input logic [15:0] k, input int n);
        @(negedge clk);
        {rx[c].ms_rei, rx[c].b2_err, rx[c].b1_valid, rx[c].k_valid} = f;
        rx[c].b1_mask = m;
        rx[c].k_value = k;
        repeat (n) @(negedge clk);
        {rx[c].ms_rei, rx[c].b2_err, rx[c].b1_valid, rx[c].k_valid} = 4'h0;
        // released data is not left at the last value
        rx[c].b1_mask = ~m;
        rx[c].k_value = ~k;
    endtask
endmodule

/* File: verification/sir_section_irq_tb_top.sv */
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module sir_section_irq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] ch; logic r1; logic [2:0] bt; logic [2:0] kind; logic [5:0] lv;} sir_row_t;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    sir_pkg::sir_cpu_t cpu_req = '0;
    logic [7:0] cpu_rdata;
    sir_pkg::sir_rx_t [2:0] rx_in;
    logic irq;
    int n_mismatch = 0;
    int total_checks = 0;
    // ----------
    // rows: channel, enable byte 1, bit, kind (0 level, 1 rei, 2 b2, 3 b1, 4 k), level mask
    // ----------
    sir_row_t rows [11] = '{
        '{2'h0, 1'b0, 3'h7, 3'h0, 6'h20},
        '{2'h1, 1'b0, 3'h6, 3'h0, 6'h10},
        '{2'h2, 1'b0, 3'h5, 3'h1, 6'h00},
        '{2'h0, 1'b0, 3'h4, 3'h2, 6'h00},
        '{2'h1, 1'b0, 3'h3, 3'h3, 6'h00},
        '{2'h2, 1'b0, 3'h2, 3'h0, 6'h08},
        '{2'h0, 1'b0, 3'h1, 3'h0, 6'h04},
        '{2'h1, 1'b0, 3'h0, 3'h0, 6'h02},
        '{2'h1, 1'b0, 3'h0, 3'h0, 6'h02},
        '{2'h2, 1'b1, 3'h1, 3'h0, 6'h01},
        '{2'h0, 1'b1, 3'h0, 3'h4, 6'h00}};
    sir_section_irq #(.CHANNELS(3)) u_dut (.clk(clk), .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
        .rx_in(rx_in), .irq(irq));
    sir_rx_model u_rx (.clk(clk), .rx(rx_in));
    always #5 clk = ~clk;
    function automatic logic [7:0] cc(input int c);
        return sir_pkg::CHAN_FIRST + 8'(c);
    endfunction
    task automatic do_rst;
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
    endtask
    task automatic wr(input logic [7:0] ch, input logic [11:0] o, input logic [7:0] d);
        @(negedge clk);
        cpu_req.wr = 1'b1;
        cpu_req.addr = {ch, o};
        cpu_req.wdata = d;
        @(negedge clk);
        cpu_req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] ch, input logic [11:0] o, input logic [7:0] e);
        @(negedge clk);
        cpu_req.rd = 1'b1;
        cpu_req.addr = {ch, o};
        @(negedge clk);
        cpu_req.rd = 1'b0;
        `CHK(cpu_rdata, e)
    endtask
    task automatic run(input sir_row_t r);
        logic [11:0] eo;
        logic [7:0] b;
        eo = r.r1 ? sir_pkg::OFS_IRQ_ENABLE1 : sir_pkg::OFS_IRQ_ENABLE0;
        b = 8'h01 << r.bt;
        wr(cc(r.ch), eo, b);
        if (r.kind == 3'h0)
            u_rx.lv(r.ch, r.lv);
        else
            u_rx.ev(r.ch, 4'h8 >> (r.kind - 3'h1), 8'h01, 16'h1234, (r.kind == 3'h4) ? 3 : 1);
        repeat (3) @(negedge clk);
        `CHK(irq, 1'b1)
        rd(cc(r.ch), r.r1 ? sir_pkg::OFS_IRQ_STATUS1 : sir_pkg::OFS_IRQ_STATUS0, b);
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b0)
        wr(cc(r.ch), eo, 8'h00);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // about 9k cycles of tests; three times that means a hang
    initial
    begin
        #300us;
        n_mismatch++;
        report_and_stop();
    end
    initial
    begin
        do_rst();
        for (int c = 0; c < 3; c++)
        begin
            rd(cc(c), sir_pkg::OFS_IRQ_ENABLE0, 8'h00);
            rd(cc(c), sir_pkg::OFS_TALLY3, 8'h00);
            rd(cc(c), sir_pkg::OFS_TALLY2, 8'h00);
        end
        rd(8'h04, sir_pkg::OFS_IRQ_ENABLE0, 8'h00);
        rd(8'h08, sir_pkg::OFS_IRQ_ENABLE0, 8'h00);
        wr(cc(2), sir_pkg::OFS_IRQ_ENABLE0, 8'hA5);
        rd(cc(2), sir_pkg::OFS_IRQ_ENABLE0, 8'hA5);
        wr(cc(2), sir_pkg::OFS_IRQ_ENABLE1, 8'hFF);
        rd(cc(2), sir_pkg::OFS_IRQ_ENABLE1, 8'hFB);
        wr(cc(2), sir_pkg::OFS_IRQ_ENABLE0, 8'h00);
        wr(cc(2), sir_pkg::OFS_IRQ_ENABLE1, 8'h00);
        foreach (rows[i])
            run(rows[i]);
        // a pending event stays silent until its enable is set
        u_rx.lv(2, 6'h04);
        repeat (3) @(negedge clk);
        `CHK(irq, 1'b0)
        wr(cc(2), sir_pkg::OFS_IRQ_ENABLE0, 8'h02);
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b1)
        rd(cc(2), sir_pkg::OFS_IRQ_STATUS0, 8'h02);
        wr(cc(2), sir_pkg::OFS_IRQ_ENABLE0, 8'h00);
        // five-frame persistence: four frames must not be accepted
        wr(cc(2), sir_pkg::OFS_CONTROL, 8'h02);
        wr(cc(2), sir_pkg::OFS_IRQ_ENABLE1, 8'h01);
        u_rx.ev(2, 4'h1, 8'h00, 16'hBEEF, 4);
        repeat (3) @(negedge clk);
        `CHK(irq, 1'b0)
        u_rx.ev(2, 4'h1, 8'h00, 16'hBEEF, 1);
        repeat (3) @(negedge clk);
        `CHK(irq, 1'b1)
        rd(cc(2), sir_pkg::OFS_K1_ACCEPTED, 8'hBE);
        rd(cc(2), sir_pkg::OFS_K2_ACCEPTED, 8'hEF);
        rd(cc(2), sir_pkg::OFS_IRQ_STATUS1, 8'h01);
        do_rst();
        rd(cc(0), sir_pkg::OFS_DEFECT_STATE, 8'h24);
        u_rx.ev(0, 4'h2, 8'h07, 16'h0000, 3);
        rd(cc(0), sir_pkg::OFS_TALLY0, 8'h09);
        rd(cc(0), sir_pkg::OFS_TALLY0, 8'h00);
        wr(cc(1), sir_pkg::OFS_CONTROL, 8'h01);
        u_rx.ev(1, 4'h2, 8'h81, 16'h0000, 5);
        u_rx.ev(1, 4'h2, 8'h00, 16'h0000, 1);
        rd(cc(1), sir_pkg::OFS_TALLY0, 8'h05);
        // 8192 frames of eight wrong bits carry exactly into bit 16
        u_rx.ev(2, 4'h2, 8'hFF, 16'h0000, 8192);
        rd(cc(2), sir_pkg::OFS_TALLY3, 8'h00);
        rd(cc(2), sir_pkg::OFS_TALLY2, 8'h01);
        rd(cc(2), sir_pkg::OFS_TALLY2, 8'h00);
        rd(cc(2), sir_pkg::OFS_TALLY1, 8'h00);
        report_and_stop();
    end
endmodule
